// file: hdl/aopms_pkg.sv
package aopms_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // typical internal serial clock period per divider code, ns
    localparam int SCLK_PERIOD_NS [4] = '{40, 70, 140, 280};

    // half period in clock cycles, rounded down, never below one
    function automatic int half_cyc(input int period_ns);
        int c;
        c = period_ns / (2 * CLK_PERIOD_NS);
        return (c < 1) ? 1 : c;
    endfunction

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] SCFG_OFS  = 8'h08;
    localparam logic [3:0] CTRL_RST  = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // data path sizes
    // ------------------------------------------------------------
    localparam int         FIFO_DEPTH = 16;
    localparam int         WORD_W     = 32;
    localparam logic [4:0] FRAME_LAST = 5'h1F;
    localparam logic [1:0] DIV_FAST   = 2'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] chan_a;
        logic [15:0] chan_b;
    } aopms_result_type;

    typedef struct packed {
        logic power_mode;
        logic input_pair_select;
        logic byte_order_select;
        logic interface_select;
    } aopms_ctrl_type;

    // serial port inputs on shared data pins 7..2
    typedef struct packed {
        logic       read_mode_or_chain_input;
        logic       clock_invert;
        logic       sync_polarity_select;
        logic       clock_source_select;
        logic [1:0] serial_clock_divider;
    } aopms_sercfg_type;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_MASTER,
        SER_SLAVE
    } aopms_ser_state_type;

endpackage

// file: hdl/aopms_fifo.sv
`timescale 1ns/1ps
module aopms_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------
    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rd_ptr_r];

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // pointers, level and registered flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            cnt_r       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            cnt_r       <= cnt_nxt;
            in_ready_o  <= (cnt_nxt != (AW+1)'(DEPTH));
            out_valid_o <= (cnt_nxt != '0);
        end
    end
endmodule

// file: hdl/aopms_port.sv
`timescale 1ns/1ps
// Operation
// - input pair select chooses sampled pair
// - byte order swaps parallel high/low bytes
// - channel pin picks A high, B low
// - serial order: A first when pin high
// - power mode pin selects reduced power
// - interface select: low parallel, high serial
// - serial mode floats data bits 0,1
// - serial mode turns pins 7..2 into inputs
// - divider only in master read-after-conversion
// - clock source low master, high slave
// - sync polarity pin sets frame-sync level
// - divider codes give 80/80/80/240 ns clock
// - read mode: during or after conversion
// - 32-bit shift register, MSB first out
module aopms_port
    import aopms_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [7:0]       s_axi_awaddr_i,
    input  wire logic             s_axi_awvalid_i,
    output logic                  s_axi_awready_o,
    input  wire logic [31:0]      s_axi_wdata_i,
    input  wire logic [3:0]       s_axi_wstrb_i,
    input  wire logic             s_axi_wvalid_i,
    output logic                  s_axi_wready_o,
    output logic [1:0]            s_axi_bresp_o,
    output logic                  s_axi_bvalid_o,
    input  wire logic             s_axi_bready_i,
    input  wire logic [7:0]       s_axi_araddr_i,
    input  wire logic             s_axi_arvalid_i,
    output logic                  s_axi_arready_o,
    output logic [31:0]           s_axi_rdata_o,
    output logic [1:0]            s_axi_rresp_o,
    output logic                  s_axi_rvalid_o,
    input  wire logic             s_axi_rready_i,
    input  wire aopms_result_type res_i,
    input  wire logic             res_valid_i,
    output logic                  res_ready_o,
    input  wire logic             conv_busy_i,
    output logic                  input_pair_select_o,
    output logic                  power_mode_o,
    input  wire logic             chan_select_i,
    input  wire logic             next_word_i,
    input  wire logic [15:0]      d_i,
    output logic [15:0]           d_o,
    output logic [15:0]           d_oe_o,
    input  wire logic             sclk_i,
    output logic                  sclk_o,
    output logic                  sclk_oe_o,
    output logic                  sync_o,
    output logic                  sync_oe_o
);
    aopms_ctrl_type      ctrl_r;
    aopms_sercfg_type    scfg;
    aopms_result_type    fifo_dout;
    aopms_result_type    par_word_r;
    aopms_ser_state_type ser_state_r;
    logic [8:0]          sync1_r;
    logic [8:0]          sync2_r;
    logic                nw_d_r;
    logic                sck_d_r;
    logic                chan_sel;
    logic                nw_rise;
    logic                sck_rise;
    logic                fifo_valid;
    logic                fifo_pop;
    logic                par_loaded_r;
    logic                ser_start;
    logic                master_tick;
    logic [1:0]          div_code;
    logic [1:0]          half_lim;
    logic [1:0]          half_cnt_r;
    logic                sclk_r;
    logic [4:0]          bit_cnt_r;
    logic [31:0]         shreg_r;
    logic [15:0]         par_sel;
    logic                aw_held_r;
    logic                w_held_r;
    logic [7:0]          awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    logic [31:0]         rd_nxt;
    logic [2:0]          settle_r;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two flops for every pin level, edges taken after the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            nw_d_r  <= 1'b0;
            sck_d_r <= 1'b0;
        end else begin
            sync1_r <= {d_i[7:2], chan_select_i, next_word_i, sclk_i};
            sync2_r <= sync1_r;
            nw_d_r  <= sync2_r[1];
            sck_d_r <= sync2_r[0];
        end
    end

    assign scfg     = sync2_r[8:3]; // pins 7..2 as serial inputs
    assign chan_sel = sync2_r[2];
    assign nw_rise  = sync2_r[1] && !nw_d_r;
    assign sck_rise = sync2_r[0] && !sck_d_r;

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    aopms_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (res_i),
        .in_valid_i  (res_valid_i),
        .in_ready_o  (res_ready_o),
        .out_data_o  (fifo_dout),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // serial frame may start once conversion allows it
    assign ser_start = ctrl_r.interface_select && fifo_valid && (ser_state_r == SER_IDLE)
                     && (&settle_r) // config pins read back before any frame
                     && (scfg.clock_source_select || scfg.read_mode_or_chain_input
                         || !conv_busy_i);
    assign fifo_pop  = ctrl_r.interface_select ? ser_start
                     : (fifo_valid && (!par_loaded_r || nw_rise));

    // serial config pins still show the old parallel data until released
    // and passed through both synchroniser flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_r <= '0;
        end else begin
            settle_r <= {settle_r[1:0], ctrl_r.interface_select};
        end
    end

    // ------------------------------------------------------------
    // parallel word holding
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            par_word_r   <= '0;
            par_loaded_r <= 1'b0;
        end else if (!ctrl_r.interface_select && fifo_pop) begin
            par_word_r   <= fifo_dout;
            par_loaded_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // serial clock rate
    // ------------------------------------------------------------
    // divider honoured only in master read-after-conversion
    assign div_code = scfg.read_mode_or_chain_input ? DIV_FAST
                    : scfg.serial_clock_divider;
    always_comb begin
        unique case (div_code)
            2'h0:    half_lim = 2'(half_cyc(SCLK_PERIOD_NS[0]) - 1);
            2'h1:    half_lim = 2'(half_cyc(SCLK_PERIOD_NS[1]) - 1);
            2'h2:    half_lim = 2'(half_cyc(SCLK_PERIOD_NS[2]) - 1);
            default: half_lim = 2'(half_cyc(SCLK_PERIOD_NS[3]) - 1);
        endcase
    end
    assign master_tick = (half_cnt_r == half_lim);

    // ------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ser_state_r <= SER_IDLE;
            half_cnt_r  <= '0;
            sclk_r      <= 1'b0;
            bit_cnt_r   <= '0;
            shreg_r     <= '0;
        end else if (!ctrl_r.interface_select) begin
            ser_state_r <= SER_IDLE; // parallel mode drops any frame
            sclk_r      <= 1'b0;
        end else begin
            unique case (ser_state_r)
                SER_IDLE: begin
                    half_cnt_r <= '0;
                    bit_cnt_r  <= '0;
                    sclk_r     <= 1'b0;
                    if (ser_start) begin
                        // channel order in the 32-bit frame
                        shreg_r     <= chan_sel ? {fifo_dout.chan_a, fifo_dout.chan_b}
                                                : {fifo_dout.chan_b, fifo_dout.chan_a};
                        ser_state_r <= scfg.clock_source_select ? SER_SLAVE
                                                                : SER_MASTER;
                    end
                end
                SER_MASTER: begin
                    half_cnt_r <= master_tick ? 2'h0 : half_cnt_r + 2'h1;
                    if (master_tick) begin
                        sclk_r <= !sclk_r;
                        if (sclk_r) begin
                            shreg_r   <= {shreg_r[30:0], 1'b0}; // msb first
                            bit_cnt_r <= bit_cnt_r + 5'h01;
                            if (bit_cnt_r == FRAME_LAST) begin
                                ser_state_r <= SER_IDLE;
                            end
                        end
                    end
                end
                SER_SLAVE: begin
                    if (sck_rise) begin
                        // chain input fills from the bottom
                        shreg_r   <= {shreg_r[30:0], scfg.read_mode_or_chain_input};
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == FRAME_LAST) begin
                            ser_state_r <= SER_IDLE;
                        end
                    end
                end
                default: ser_state_r <= SER_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers, all registered
    // ------------------------------------------------------------
    assign par_sel = chan_sel ? par_word_r.chan_a : par_word_r.chan_b;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d_o       <= '0;
            d_oe_o    <= '0;
            sclk_o    <= 1'b0;
            sclk_oe_o <= 1'b0;
            sync_o    <= 1'b0;
            sync_oe_o <= 1'b0;
        end else if (!ctrl_r.interface_select) begin
            // parallel port, byte order by control bit
            d_o       <= ctrl_r.byte_order_select ? {par_sel[7:0], par_sel[15:8]} : par_sel;
            d_oe_o    <= 16'hFFFF;
            sclk_oe_o <= 1'b0;
            sync_oe_o <= 1'b0;
        end else begin
            // of the data pins only the serial output pin 8 is driven
            d_o       <= {7'h00, shreg_r[31], 8'h00};
            d_oe_o    <= 16'h0100;
            sclk_o    <= sclk_r;
            sclk_oe_o <= !scfg.clock_source_select;
            sync_o    <= (ser_state_r == SER_MASTER) ^ scfg.sync_polarity_select;
            sync_oe_o <= !scfg.clock_source_select;
        end
    end

    // ------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_pair_select_o <= 1'b0;
            power_mode_o        <= 1'b0;
        end else begin
            input_pair_select_o <= ctrl_r.input_pair_select;
            power_mode_o        <= ctrl_r.power_mode;
        end
    end

    // ------------------------------------------------------------
    // register bus, write side
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_r       <= 1'b0;
            w_held_r        <= 1'b0;
            awaddr_r        <= '0;
            wdata_r         <= '0;
            wstrb_r         <= '0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            ctrl_r          <= CTRL_RST;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_r       <= 1'b1;
                awaddr_r        <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_r       <= 1'b1;
                wdata_r        <= s_axi_wdata_i;
                wstrb_r        <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (aw_held_r && w_held_r && !s_axi_bvalid_o) begin
                aw_held_r      <= 1'b0;
                w_held_r       <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= RESP_OKAY;
                if (awaddr_r[7:2] == CTRL_OFS[7:2]) begin
                    if (wstrb_r[0]) begin
                        ctrl_r <= wdata_r[3:0];
                    end
                end else if (awaddr_r[7:2] != STAT_OFS[7:2]
                             && awaddr_r[7:2] != SCFG_OFS[7:2]) begin
                    s_axi_bresp_o <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // register bus, read side
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = '0;
        if (s_axi_araddr_i[7:2] == CTRL_OFS[7:2]) begin
            rd_nxt[3:0] = ctrl_r;
        end else if (s_axi_araddr_i[7:2] == STAT_OFS[7:2]) begin
            rd_nxt[3:0] = {par_loaded_r, ser_state_r != SER_IDLE, res_ready_o, fifo_valid};
        end else if (s_axi_araddr_i[7:2] == SCFG_OFS[7:2]) begin
            rd_nxt[6:0] = {chan_sel, scfg};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_nxt;
            s_axi_rresp_o   <= (s_axi_araddr_i[7:2] > SCFG_OFS[7:2]) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_pair_select: assert property ($changed(ctrl_r.input_pair_select) |=>
        input_pair_select_o == $past(ctrl_r.input_pair_select))
        else $error("pair select output does not follow control");
    a_byte_swap: assert property (!ctrl_r.interface_select && ctrl_r.byte_order_select
        |=> d_o[7:0] == $past(par_sel[15:8]))
        else $error("swapped byte order not presented");
    a_chan_b_pick: assert property (!ctrl_r.interface_select && !chan_sel
        && !ctrl_r.byte_order_select |=> d_o == $past(par_word_r.chan_b))
        else $error("channel B not presented with select low");
    a_serial_order: assert property (ser_start && chan_sel
        |=> shreg_r[31:16] == $past(fifo_dout.chan_a))
        else $error("channel A not first in frame");
    a_power_mode: assert property (ctrl_r.power_mode [*2] |-> power_mode_o)
        else $error("reduced power mode not driven");
    a_par_drive: assert property (!ctrl_r.interface_select |=> d_oe_o == 16'hFFFF)
        else $error("parallel bus not fully driven");
    a_serial_float: assert property (ctrl_r.interface_select |=> d_oe_o[7:0] == 8'h00)
        else $error("low data pins driven in serial mode");
    a_div_ignored: assert property (ser_state_r == SER_MASTER
        && scfg.read_mode_or_chain_input |-> half_lim == 2'h0)
        else $error("divider applied outside read-after-conversion");
    a_div_slowest: assert property (!scfg.read_mode_or_chain_input
        && scfg.serial_clock_divider == 2'h3 |-> half_lim == 2'h2)
        else $error("slowest clock half period wrong");
    a_slave_no_clk: assert property (ctrl_r.interface_select
        && scfg.clock_source_select |=> !sclk_oe_o)
        else $error("clock driven in slave mode");
    a_sync_level: assert property (ctrl_r.interface_select && ser_state_r == SER_MASTER
        |=> sync_o == !$past(scfg.sync_polarity_select))
        else $error("frame sync level wrong");
    a_wait_conv: assert property (ser_state_r == SER_IDLE && !scfg.clock_source_select
        && !scfg.read_mode_or_chain_input && conv_busy_i |-> !ser_start)
        else $error("frame started during conversion");
    a_frame_end: assert property (ctrl_r.interface_select && ser_state_r == SER_MASTER
        && master_tick && sclk_r && bit_cnt_r == FRAME_LAST |=> ser_state_r == SER_IDLE)
        else $error("master frame not 32 bits");

    c_master_frame: cover property (ser_state_r == SER_MASTER ##1 ser_state_r == SER_IDLE);
    c_slave_frame: cover property (ser_state_r == SER_SLAVE ##1 ser_state_r == SER_IDLE);
    c_par_pop: cover property (!ctrl_r.interface_select && nw_rise && fifo_pop);
    c_fifo_full: cover property (!res_ready_o);
endmodule

// file: dv/aopms_host_model.sv
`timescale 1ns/1ps
module aopms_host_model
    import aopms_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sel_i,
    input  wire logic [5:0]  cfg_i,
    input  wire logic [15:0] d_o_i,
    input  wire logic [15:0] d_oe_i,
    input  wire logic        sclk_o_i,
    input  wire logic        sync_o_i,
    output logic             chan_select_o,
    output logic [15:0]      d_i_o,
    output logic [31:0]      frame_o = 32'h0,
    output int               bits_o = 0
);
    logic sclk_q = 1'b0;
    // channel pin straight from the host
    assign chan_select_o = sel_i;
    // wire level: device where enabled, host config on 7..2, else inverted device value
    always_comb begin
        for (int i = 0; i < 16; i++) d_i_o[i] = d_oe_i[i] ? d_o_i[i] : ~d_o_i[i];
        if (d_oe_i[7:2] == 6'h00) d_i_o[7:2] = cfg_i;
    end
    // shift in serial bits on rising master clock inside the frame
    always_ff @(posedge clk_i) begin
        sclk_q <= sclk_o_i;
        if (sclk_o_i && !sclk_q && (sync_o_i ^ cfg_i[3])) begin
            frame_o <= {frame_o[30:0], d_o_i[8]};
            bits_o  <= bits_o + 1;
        end
    end
endmodule

// file: dv/tb_adc_output_port_mode_select.sv
`timescale 1ns/1ps
module tb_adc_output_port_mode_select;
    import aopms_pkg::*;
    logic clk_i = 0, rst_n_i = 0, awv = 0, wv = 0, arv = 0, rv = 0, busy = 0, sel = 1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] resp;
    aopms_result_type res = '0;
    logic [5:0] cfg = 6'h08;
    logic sck = 0;
    logic awr, wr_, bv, arr, rvl, rrdy, chs, sclko, sclkoe, synco, synoe, pairo, pwro;
    logic [1:0] br, rr;
    logic [31:0] rd, frame;
    logic [15:0] dout, doe, din;
    int bits, fail_count = 0, comparisons = 0;
    localparam aopms_result_type R0 = '{chan_a: 16'hA1B2, chan_b: 16'hC3D4};
    aopms_port uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rvl),
        .s_axi_rready_i(1'b1), .res_i(res), .res_valid_i(rv), .res_ready_o(rrdy),
        .conv_busy_i(busy), .input_pair_select_o(pairo), .power_mode_o(pwro),
        .chan_select_i(chs), .next_word_i(1'b0), .d_i(din), .d_o(dout), .d_oe_o(doe),
        .sclk_i(sck), .sclk_o(sclko), .sclk_oe_o(sclkoe), .sync_o(synco),
        .sync_oe_o(synoe));
    aopms_host_model host (.clk_i(clk_i), .sel_i(sel), .cfg_i(cfg), .d_o_i(dout),
        .d_oe_i(doe), .sclk_o_i(sclko), .sync_o_i(synco), .chan_select_o(chs),
        .d_i_o(din), .frame_o(frame), .bits_o(bits));
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", n, exp, got);
            fail_count++;
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one write, address and data offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        do begin
            @(posedge clk_i);
            if (awr) awv <= 0;
            if (wr_) wv <= 0;
        end while (bv !== 1'b1);
        resp = br;
    endtask
    task automatic axr(input logic [7:0] a);
        ara <= a; arv <= 1;
        do begin
            @(posedge clk_i);
            if (arr) arv <= 0;
        end while (rvl !== 1'b1);
        rdat = rd; resp = rr;
    endtask
    task automatic push();
        res <= R0; rv <= 1;
        do @(posedge clk_i); while (rrdy !== 1'b1);
        rv <= 0;
        @(posedge clk_i);
    endtask
    task automatic t_regs();
        axr(CTRL_OFS); chk("ctrl", rdat, 32'h0); chk("rresp", resp, RESP_OKAY);
        axr(8'h0C); chk("unmapped rd", resp, RESP_SLVERR);
        axw(8'h10, 32'h0); chk("unmapped wr", resp, RESP_SLVERR);
        axw(CTRL_OFS, 32'hC); repeat (3) @(posedge clk_i);
        chk("pair", pairo, 1'b1); chk("power", pwro, 1'b1);
    endtask
    task automatic t_par();
        push(); push(); repeat (8) @(posedge clk_i);
        chk("par a", dout, R0.chan_a); chk("par oe", doe, 16'hFFFF);
        axw(CTRL_OFS, 32'h2); repeat (4) @(posedge clk_i);
        chk("swap a", dout, 16'hB2A1);
        sel <= 0; repeat (8) @(posedge clk_i);
        chk("swap b", dout, 16'hD4C3);
    endtask
    task automatic t_ser();
        busy <= 1;
        axw(CTRL_OFS, 32'h1);
        repeat (20) @(posedge clk_i);
        chk("wait conv", bits, 0);
        busy <= 0;
        for (int n = 0; n < 3000 && bits < 32; n++) @(posedge clk_i);
        repeat (100) @(posedge clk_i);
        chk("frame", frame, {R0.chan_b, R0.chan_a});
        chk("ser oe", {doe[1:0], sclkoe, synoe}, 4'b0011);
        chk("sync idle", synco, 1'b1);
    endtask
    // slave frame clocked by the host, channel B first with select low
    task automatic t_slv();
        logic [31:0] got;
        cfg <= 6'h0C;
        repeat (4) @(posedge clk_i);
        push();
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 32; i++) begin
            got = {got[30:0], dout[8]};
            sck <= 1;
            repeat (4) @(posedge clk_i);
            sck <= 0;
            repeat (4) @(posedge clk_i);
        end
        chk("slave frame", got, {R0.chan_b, R0.chan_a});
        chk("slave oe", {sclkoe, synoe}, 2'b00);
    endtask
    task automatic t_fill();
        int n = 0;
        axw(CTRL_OFS, 32'h0);
        while (n < 20 && rrdy === 1'b1) begin
            push();
            n++;
        end
        chk("fill depth", n, FIFO_DEPTH);
        axr(STAT_OFS); chk("fifo full", {rdat[1], rrdy}, 2'b00);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i);
        t_regs(); t_par(); t_ser(); t_slv(); t_fill();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end
endmodule
